// ---- adtsc_map.svh ----
`ifndef ADTSC_MAP_SVH
`define ADTSC_MAP_SVH
// ------------------------------------------------------------
// register offsets (3-bit word index on the plain port)
// ------------------------------------------------------------
`define ADTSC_OFF_CTRL0   3'h0
`define ADTSC_OFF_CTRL1   3'h1
`define ADTSC_OFF_SENS0   3'h2
`define ADTSC_OFF_SENS1   3'h3
`define ADTSC_OFF_SENS2   3'h4
`define ADTSC_OFF_SENS3   3'h5
`define ADTSC_OFF_RES_HI  3'h6
`define ADTSC_OFF_RES_LO  3'h7
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define ADTSC_B_START     7
`define ADTSC_B_BUSY      6
`define ADTSC_B_CONV_EN   5
`define ADTSC_B_FMT       4
`define ADTSC_B_AUTO      7
`define ADTSC_B_IDLE      5
`define ADTSC_B_REFERENCE_SELECT     4
`define ADTSC_B_REFOUT    7
`define ADTSC_B_GAIN2     6
`define ADTSC_B_GAIN1     5
`define ADTSC_B_SENS_EN   7
`define ADTSC_B_AMP2_EN   6
`define ADTSC_B_AMP1_EN   5
`define ADTSC_B_POSREF    7
`define ADTSC_B_BIAS      6
`define ADTSC_B_AMP1_IN   5
// ------------------------------------------------------------
// writable masks and reset values
// ------------------------------------------------------------
`define ADTSC_MASK_CTRL0  8'hbf
`define ADTSC_MASK_CTRL1  8'hb7
`define ADTSC_MASK_SENS0  8'he0
`define ADTSC_MASK_SENS1  8'he0
`define ADTSC_MASK_SENS2  8'hc3
`define ADTSC_MASK_SENS3  8'h20
`define ADTSC_RST_CTRL0   8'h00
`define ADTSC_RST_CTRL1   8'h00
`define ADTSC_RST_SENS0   8'h40
`define ADTSC_RST_SENS1   8'h00
`define ADTSC_RST_SENS2   8'h00
`define ADTSC_RST_SENS3   8'h00
// ------------------------------------------------------------
// timing counts in conversion clock periods
// ------------------------------------------------------------
`define ADTSC_TS_MULT     5
`define ADTSC_TS_EXTRA    17
`define ADTSC_EXT_CYCLES  8'd16
`endif

// ---- adtsc_pkg.sv ----
package adtsc_pkg;
  // ----------------------------------------------------------
  // types
  // ----------------------------------------------------------
  typedef enum logic [1:0] {
    ADTSC_IDLE  = 2'b00,
    ADTSC_ARMED = 2'b01,
    ADTSC_RUN   = 2'b10
  } adtsc_state_t;

  // host register port
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } adtsc_bus_t;

  // static analog controls
  typedef struct packed {
    logic       conv_power;
    logic [3:0] ext_channel;
    logic       sel_internal;
    logic       sens_ref_sel;
    logic [1:0] ref_src;
    logic       amp2_gain;
    logic       amp1_gain;
    logic       amp1_input;
    logic       sensor_en;
    logic       amp1_en;
    logic       amp2_en;
    logic       bias_sel;
  } adtsc_analog_t;
endpackage

// ---- adtsc_prescaler.sv ----
`timescale 1ns/1ps
// conversion clock tick generator: fsys / 2^code
module adtsc_prescaler (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [2:0] code,
  output logic            tick
);
  logic [6:0] cnt;  // free counter while running

  // ----------------------------------------------------------
  // divider
  // ----------------------------------------------------------
  function automatic logic [6:0] span(input logic [2:0] c);
    span = 7'((8'h01 << c) - 8'h01);
  endfunction

  // count up, tick on terminal
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt  <= 7'h00;
      tick <= 1'b0;
    end else if (ce) begin
      if (!run) begin  // converter off: hold divider cleared
        cnt  <= 7'h00;
        tick <= 1'b0;
      end else if (cnt >= span(code)) begin  // see [R12] see [R13]
        cnt  <= 7'h00;
        tick <= 1'b1;
      end else begin
        cnt  <= cnt + 7'h01;
        tick <= 1'b0;
      end
    end
  end
endmodule // adtsc_prescaler

// ---- adtsc_sequencer.sv ----
`timescale 1ns/1ps
// counts conversion clock ticks for one conversion
module adtsc_sequencer (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       launch,
  input  wire logic       tick,
  input  wire logic [7:0] length,
  output logic            running,
  output logic            done
);
  logic [7:0] left;  // ticks remaining

  // load on launch, count down on tick
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      left    <= 8'h00;
      running <= 1'b0;
      done    <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (launch) begin
        left    <= length;
        running <= 1'b1;
      end else if (running && tick) begin
        if (left <= 8'h01) begin
          running <= 1'b0;
          done    <= 1'b1;
        end
        left <= left - 8'h01;
      end
    end
  end
endmodule // adtsc_sequencer

// ---- adtsc_ctrl.sv ----
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "adtsc_map.svh"
//
// Contract
// [R1] start bit high then low starts one
// [R2] busy set at start, cleared on done
// [R3] converter off clears both result bytes
// [R4] format bit picks result byte alignment
// [R5] codes 0000-0111 pick external inputs 0-7
// [R6] top select bit needs sensor enable
// [R7] reference output bit picks sensor signal
// [R8] auto mode restarts after each completion
// [R9] software reads results in completion handler
// [R10] idle mode stalls cpu during conversion
// [R11] reference select applies when positive-ref set
// [R12] codes 000-101 divide by 1 to 32
// [R13] codes 110, 111 divide by 64, 128
// [R14] sensor conversion clock 500 kHz to 1 MHz
// [R15] software waits settle time after sensor enable
// [R16] sensor clock select gives 4, 8, 16
// [R17] sensor conversion lasts 5N+17 clock periods
// [R18] positive-ref low picks sensor reference
// [R19] internal-use sensor bits stay low
// [R20] unimplemented bits read zero, ignore writes
// [R21] amp2 gain output, resets to one
module adtsc_ctrl (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    ce,
  input  wire adtsc_pkg::adtsc_bus_t   bus,
  input  wire logic [11:0]             core_result,
  output logic [7:0]                   rdata,
  output logic                         cpu_stall,
  output logic                         conv_running,
  output logic                         sample_strobe,
  output adtsc_pkg::adtsc_analog_t     analog
);
  import adtsc_pkg::*;

  // ----------------------------------------------------------
  // registers
  // ----------------------------------------------------------
  logic [7:0]   converter_control_0;  // start, enable, format, select
  logic [7:0]   converter_control_1;  // auto, idle, reference_select, clock
  logic [7:0]   sensor_control_0;     // ref out, gains
  logic [7:0]   sensor_control_1;     // sensor and amp enables
  logic [7:0]   sensor_control_2;     // pos ref, bias, sensor clock
  logic [7:0]   sensor_control_3;     // amp1 input
  logic         conv_busy_flag;       // busy status
  logic [11:0]  result;               // latched conversion word
  adtsc_state_t state;                // start handshake state
  logic         launch;               // one conversion begins
  logic         tick;                 // conversion clock tick
  logic         seq_running;          // sequencer active
  logic         seq_done;             // conversion complete pulse
  logic [7:0]   conv_length;          // ticks per conversion
  logic         sensor_path;          // internal signal chosen

  // ----------------------------------------------------------
  // field decode
  // ----------------------------------------------------------
  wire       converter_enable           = converter_control_0[`ADTSC_B_CONV_EN];
  wire       result_format_select       = converter_control_0[`ADTSC_B_FMT];
  wire [3:0] input_select               = converter_control_0[3:0];
  wire       auto_conversion_enable     = converter_control_1[`ADTSC_B_AUTO];
  wire       cpu_idle_conversion_enable = converter_control_1[`ADTSC_B_IDLE];
  wire       reference_select           = converter_control_1[`ADTSC_B_REFERENCE_SELECT];
  wire [2:0] conv_clock_select          = converter_control_1[2:0];
  wire       sensor_ref_output_enable   = sensor_control_0[`ADTSC_B_REFOUT];
  wire       amp2_gain_select           = sensor_control_0[`ADTSC_B_GAIN2];
  wire       amp1_gain_select           = sensor_control_0[`ADTSC_B_GAIN1];
  wire       sensor_enable              = sensor_control_1[`ADTSC_B_SENS_EN];
  wire       positive_ref_select        = sensor_control_2[`ADTSC_B_POSREF];
  wire [1:0] sensor_clock_select        = sensor_control_2[1:0];
  wire       amp1_input_select          = sensor_control_3[`ADTSC_B_AMP1_IN];

  // sensor clock ratio N from select code
  function automatic logic [7:0] sens_ratio(input logic [1:0] s);
    unique case (s)
      2'b00:   sens_ratio = 8'd4;   // see [R16]
      2'b01:   sens_ratio = 8'd8;   // see [R16]
      default: sens_ratio = 8'd16;  // see [R16]
    endcase
  endfunction

  // masked register update
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd, input logic [7:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction

  // internal signal only when sensor is enabled
  assign sensor_path = input_select[3] & sensor_enable;  // see [R6]

  // length: sensor path 5N+17 ticks, else fixed
  always_comb begin
    if (sensor_path) begin
      conv_length = 8'(`ADTSC_TS_MULT * sens_ratio(sensor_clock_select) + `ADTSC_TS_EXTRA);  // see [R17]
    end else begin
      conv_length = `ADTSC_EXT_CYCLES;
    end
  end

  // ----------------------------------------------------------
  // register writes
  // ----------------------------------------------------------
  // control 0: busy bit is read-only, held apart
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      converter_control_0 <= `ADTSC_RST_CTRL0;
    end else if (ce && bus.wr && bus.addr == `ADTSC_OFF_CTRL0) begin
      converter_control_0 <= merge(converter_control_0, bus.wdata, `ADTSC_MASK_CTRL0);  // see [R2] see [R20]
    end
  end

  // control 1
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      converter_control_1 <= `ADTSC_RST_CTRL1;
    end else if (ce && bus.wr && bus.addr == `ADTSC_OFF_CTRL1) begin
      converter_control_1 <= merge(converter_control_1, bus.wdata, `ADTSC_MASK_CTRL1);  // see [R20]
    end
  end

  // sensor registers; internal-use bits never writable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sensor_control_0 <= `ADTSC_RST_SENS0;  // see [R21]
      sensor_control_1 <= `ADTSC_RST_SENS1;
      sensor_control_2 <= `ADTSC_RST_SENS2;
      sensor_control_3 <= `ADTSC_RST_SENS3;
    end else if (ce && bus.wr) begin
      unique case (bus.addr)
        `ADTSC_OFF_SENS0: sensor_control_0 <= merge(sensor_control_0, bus.wdata, `ADTSC_MASK_SENS0);  // see [R20]
        `ADTSC_OFF_SENS1: sensor_control_1 <= merge(sensor_control_1, bus.wdata, `ADTSC_MASK_SENS1);
        `ADTSC_OFF_SENS2: sensor_control_2 <= merge(sensor_control_2, bus.wdata, `ADTSC_MASK_SENS2);  // see [R19]
        `ADTSC_OFF_SENS3: sensor_control_3 <= merge(sensor_control_3, bus.wdata, `ADTSC_MASK_SENS3);
        default: ;  // control offsets handled elsewhere, result offsets ignore writes
      endcase
    end
  end

  // ----------------------------------------------------------
  // start handshake
  // ----------------------------------------------------------
  // armed on start high, fire on start low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state  <= ADTSC_IDLE;
      launch <= 1'b0;
    end else if (ce) begin
      launch <= 1'b0;
      unique case (state)
        ADTSC_IDLE: begin
          if (converter_control_0[`ADTSC_B_START]) begin
            state <= ADTSC_ARMED;
          end
        end
        ADTSC_ARMED: begin
          if (!converter_control_0[`ADTSC_B_START]) begin
            state  <= ADTSC_RUN;
            launch <= converter_enable;  // see [R1]
          end
        end
        ADTSC_RUN: begin
          if (seq_done && auto_conversion_enable && converter_enable) begin
            launch <= 1'b1;  // see [R8]
          end else if (!seq_running && !launch) begin
            state <= ADTSC_IDLE;
          end
        end
        default: state <= ADTSC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------
  // busy flag
  // ----------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      conv_busy_flag <= 1'b0;
    end else if (ce) begin
      if (launch) begin
        conv_busy_flag <= 1'b1;  // see [R2]
      end else if (seq_done || !converter_enable) begin
        conv_busy_flag <= 1'b0;  // see [R2]
      end
    end
  end

  // ----------------------------------------------------------
  // result capture
  // ----------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result <= 12'h000;
    end else if (ce) begin
      if (!converter_enable) begin
        result <= 12'h000;  // see [R3]
      end else if (seq_done) begin
        result <= core_result;
      end
    end
  end

  // ----------------------------------------------------------
  // read port, data one cycle after strobe
  // ----------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (ce) begin
      if (bus.rd) begin
        unique case (bus.addr)
          `ADTSC_OFF_CTRL0:  rdata <= {converter_control_0[7], conv_busy_flag, converter_control_0[5:0]};
          `ADTSC_OFF_CTRL1:  rdata <= converter_control_1;  // see [R20]
          `ADTSC_OFF_SENS0:  rdata <= sensor_control_0;
          `ADTSC_OFF_SENS1:  rdata <= sensor_control_1;
          `ADTSC_OFF_SENS2:  rdata <= sensor_control_2;
          `ADTSC_OFF_SENS3:  rdata <= sensor_control_3;
          `ADTSC_OFF_RES_HI: rdata <= result_format_select ? {4'h0, result[11:8]} : result[11:4];  // see [R4]
          `ADTSC_OFF_RES_LO: rdata <= result_format_select ? result[7:0] : {result[3:0], 4'h0};  // see [R4]
          default:           rdata <= 8'h00;
        endcase
      end else begin
        rdata <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------
  // status and analog outputs
  // ----------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cpu_stall     <= 1'b0;
      conv_running  <= 1'b0;
      sample_strobe <= 1'b0;
    end else if (ce) begin
      cpu_stall     <= cpu_idle_conversion_enable && (launch || (seq_running && !seq_done));  // see [R10]
      conv_running  <= launch || (seq_running && !seq_done);
      sample_strobe <= launch;
    end
  end

  // static analog controls
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      analog <= '0;
      analog.amp2_gain <= 1'b1;  // see [R21]
    end else if (ce) begin
      analog.conv_power   <= converter_enable;  // see [R3]
      analog.ext_channel  <= {1'b0, input_select[2:0]};  // see [R5] see [R6]
      analog.sel_internal <= sensor_path;  // see [R6]
      analog.sens_ref_sel <= sensor_ref_output_enable;  // see [R7]
      analog.ref_src      <= positive_ref_select ? {1'b0, reference_select} : 2'b10;  // see [R11] see [R18]
      analog.amp2_gain    <= amp2_gain_select;  // see [R21]
      analog.amp1_gain    <= amp1_gain_select;
      analog.amp1_input   <= amp1_input_select;
      analog.sensor_en    <= sensor_enable;
      analog.amp1_en      <= sensor_control_1[`ADTSC_B_AMP1_EN];
      analog.amp2_en      <= sensor_control_1[`ADTSC_B_AMP2_EN];
      analog.bias_sel     <= sensor_control_2[`ADTSC_B_BIAS];
    end
  end

  // ----------------------------------------------------------
  // submodules
  // ----------------------------------------------------------
  adtsc_prescaler u_presc (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .run   (converter_enable),
    .code  (conv_clock_select),
    .tick  (tick)
  );

  adtsc_sequencer u_seq (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .launch  (launch),
    .tick    (tick),
    .length  (conv_length),
    .running (seq_running),
    .done    (seq_done)
  );
endmodule // adtsc_ctrl

// ---- adtsc_core_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------
// converter core stand-in: the word names its routed source
// ----------------------------------------------------------
module adtsc_core_model (
  input  wire adtsc_pkg::adtsc_analog_t analog,
  output logic [11:0]                   core_result
);
  import adtsc_pkg::*;
  // powered down core shows a pattern, not a held word
  always_comb begin
    if (!analog.conv_power) core_result = 12'hfff;
    else if (analog.sel_internal) core_result = analog.sens_ref_sel ? 12'h3c1 : 12'h3c0;
    else core_result = {8'ha5, 1'b0, analog.ext_channel[2:0]};
  end
endmodule // adtsc_core_model

// ---- adtsc_ctrl_asserts.sv ----
`timescale 1ns/1ps
module adtsc_ctrl_asserts (
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic                    ce,
  input wire adtsc_pkg::adtsc_bus_t   bus,
  input wire logic [11:0]             core_result,
  input wire logic [7:0]              rdata,
  input wire logic                    cpu_stall,
  input wire logic                    conv_running,
  input wire logic                    sample_strobe,
  input wire adtsc_pkg::adtsc_analog_t analog
);
  import adtsc_pkg::*;
  // ----------------------------------------------------------
  // port relations
  // ----------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_RD_IDLE: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data not zero outside a read");
  AST_BUSY_BIT: assert property ($past(bus.rd) && $past(bus.addr) == 3'h0 |-> rdata[6] == $past(conv_running))
    else $error("busy bit disagrees with conversion");
  AST_STALL: assert property (cpu_stall |-> conv_running)
    else $error("cpu stalled with no conversion");
  AST_STROBE: assert property ($rose(conv_running) |-> sample_strobe)
    else $error("conversion began without sample strobe");
  AST_PULSE: assert property (sample_strobe |=> !sample_strobe)
    else $error("sample strobe longer than one cycle");
  AST_SENS_GATE: assert property (!analog.sensor_en |-> !analog.sel_internal)
    else $error("internal path chosen with sensor off");
  AST_REF_CODE: assert property (analog.ref_src != 2'b11)
    else $error("reference code out of range");
  AST_GAIN_RST: assert property ($rose(rst_n) |-> analog.amp2_gain)
    else $error("amp2 gain not one after reset");
  AST_OFF_IDLE: assert property (!analog.conv_power ##1 !analog.conv_power |-> !conv_running)
    else $error("conversion runs with converter off");
  AST_OFF_RES: assert property ($past(bus.rd) && $past(bus.addr) >= 3'h6 && $past(!analog.conv_power)
    && $past(!analog.conv_power, 2) |-> rdata == 8'h00)
    else $error("result not cleared with converter off");
  // main scenarios
  cover property ($rose(conv_running));
  cover property (cpu_stall);
  cover property (analog.sel_internal && conv_running);
endmodule // adtsc_ctrl_asserts

bind adtsc_ctrl adtsc_ctrl_asserts u_asserts (.clk(clk), .rst_n(rst_n), .ce(ce), .bus(bus),
  .core_result(core_result), .rdata(rdata), .cpu_stall(cpu_stall), .conv_running(conv_running),
  .sample_strobe(sample_strobe), .analog(analog));

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import adtsc_pkg::*;
  logic          clk;
  logic          rst_n;
  adtsc_bus_t    bus;
  logic [11:0]   core_result;
  logic [7:0]    rdata;
  logic          cpu_stall;
  logic          conv_running;
  logic          sample_strobe;
  adtsc_analog_t analog;
  int            mismatches;
  int            checks_done;
  int            n;
  logic [7:0]    rd_val;
  logic [7:0]    rst_tab [8] = '{8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]    msk_tab [6] = '{8'h3f, 8'hb7, 8'he0, 8'he0, 8'hc3, 8'h20};
  // ----------------------------------------------------------
  // design and core model
  // ----------------------------------------------------------
  adtsc_ctrl u_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .bus(bus), .core_result(core_result),
    .rdata(rdata), .cpu_stall(cpu_stall), .conv_running(conv_running),
    .sample_strobe(sample_strobe), .analog(analog));
  adtsc_core_model u_core (.analog(analog), .core_result(core_result));
  always #25 clk = ~clk;
  // ----------------------------------------------------------
  // bus tasks and compare
  // ----------------------------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge clk);
    bus.wr    <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge clk);
    bus.rd   <= 1'b0;
    #1 rd_val = rdata;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // start pulse, then time the busy span in clock cycles
  task automatic conv(input logic [7:0] c, input int len, input int tol);
    int i;
    wr(3'h0, c | 8'h80);
    wr(3'h0, c);
    n = 0;
    i = 0;
    #1;
    while (conv_running !== 1'b1 && i < 20) begin
      @(posedge clk);
      #1;
      i++;
    end
    while (conv_running === 1'b1 && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("conv length", len, (n >= len - tol && n <= len + tol) ? len : n);
  endtask
  // let a register write reach the registered analog outputs
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic summarize();
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------
  initial begin
    #(50 * 40000);
    mismatches++;
    summarize();
  end
  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    bus = '0;
    mismatches = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(i[2:0]);
      chk("reset value", rst_tab[i], rd_val);
    end
    for (int i = 0; i < 6; i++) begin
      wr(i[2:0], (i == 0) ? 8'h7f : 8'hff);
      rd(i[2:0]);
      chk("write mask", msk_tab[i], rd_val);
    end
    wr(3'h6, 8'hff);
    rd(3'h6);
    chk("result write ignored", 8'h00, rd_val);
    chk("internal path", 1'b1, analog.sel_internal);
    chk("sensor reference", 1'b1, analog.sens_ref_sel);
    chk("ref pin", 2'b01, analog.ref_src);
    wr(3'h4, 8'h00);
    settle();
    chk("ref sensor", 2'b10, analog.ref_src);
    wr(3'h1, 8'h00);
    wr(3'h4, 8'h80);
    settle();
    chk("ref supply", 2'b00, analog.ref_src);
    wr(3'h2, 8'h00);
    settle();
    chk("amp2 gain", 1'b0, analog.amp2_gain);
    chk("sensor output", 1'b0, analog.sens_ref_sel);
    wr(3'h3, 8'h00);
    settle();
    chk("top bit ignored", 1'b0, analog.sel_internal);
    chk("low bits channel", 3'h7, analog.ext_channel[2:0]);
    wr(3'h5, 8'h00);
    // start held high alone must not convert
    wr(3'h0, 8'ha3);
    repeat (10) @(posedge clk);
    #1 chk("no start on high", 1'b0, conv_running);
    for (int k = 0; k < 8; k++) begin
      wr(3'h1, k[7:0]);
      conv(8'h23, 16 << k, (1 << k) + 2);
      rd(3'h6);
      chk("result high", 8'ha5, rd_val);
      rd(3'h7);
      chk("result low", 8'h30, rd_val);
    end
    wr(3'h1, 8'h00);
    conv(8'h35, 16, 2);
    rd(3'h6);
    chk("right high", 8'h0a, rd_val);
    rd(3'h7);
    chk("right low", 8'h55, rd_val);
    // idle mode: busy and stall while running
    wr(3'h1, 8'h23);
    wr(3'h0, 8'ha3);
    wr(3'h0, 8'h23);
    repeat (3) @(posedge clk);
    rd(3'h0);
    chk("busy set", 8'h63, rd_val);
    chk("cpu stalled", 1'b1, cpu_stall);
    n = 0;
    while (conv_running === 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    rd(3'h0);
    chk("busy cleared", 8'h23, rd_val);
    chk("cpu released", 1'b0, cpu_stall);
    wr(3'h0, 8'h03);
    rd(3'h6);
    chk("off clears high", 8'h00, rd_val);
    rd(3'h7);
    chk("off clears low", 8'h00, rd_val);
    // sensor path at 625 kHz after settling
    wr(3'h1, 8'h05);
    wr(3'h3, 8'h80);
    repeat (40) @(posedge clk);
    wr(3'h2, 8'h80);
    for (int t = 0; t < 3; t++) begin
      wr(3'h4, t[7:0]);
      conv(8'h28, 32 * (5 * (4 << t) + 17), 34);
      rd(3'h6);
      chk("sensor high", 8'h3c, rd_val);
      rd(3'h7);
      chk("sensor low", 8'h10, rd_val);
    end
    // auto mode restarts with no further start
    wr(3'h3, 8'h00);
    wr(3'h1, 8'h80);
    wr(3'h0, 8'ha3);
    wr(3'h0, 8'h23);
    n = 0;
    repeat (200) begin
      @(posedge clk);
      #1;
      if (sample_strobe === 1'b1) n++;
    end
    chk("auto restarts", 1'b1, n >= 10);
    wr(3'h1, 8'h00);
    repeat (40) @(posedge clk);
    #1 chk("auto stopped", 1'b0, conv_running);
    summarize();
  end
endmodule // testbench
